// ### src/uhp_chan.sv
module uhp_chan
   import uhp_pkg::*;
(
   // clock and control
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   // reset-release capture of the prescale strap, and the live irq force level
   input wire logic capture,
   input wire logic prescPin,
   input wire logic forceIrq,
   // register access
   input wire uhp_wr_t wr,
   input wire logic rdMsts,
   output logic [DATA_W-1:0] rdData,
   // modem side and event sources
   input wire uhp_modem_t modem,
   input wire uhp_src_t src,
   // channel outputs
   output logic tick,
   output logic txAllow,
   output logic termReadyN,
   output logic irq,
   output logic irqOeN
);
   uhp_chan_st_t st_ff;
   uhp_chan_st_t nxt;
   logic [IRQ_SRC_W-1:0] pend;
   logic ctsChg;
   logic dsrChg;

   // next state: register writes, strap capture, modem status, prescaler
   always_comb begin
      nxt = st_ff;
      if (wr.stb) begin
         case (wr.addr) // [R17]
            ADR_IRQ_ENABLE: nxt.irqEn = wr.data;
            ADR_FEATURE: nxt.featReg = wr.data;
            ADR_MODEM_CTRL: nxt.modemCtrl = wr.data; // [R3]
            default: ;
         endcase
      end
      if (capture) begin
         nxt.modemCtrl[MCTL_PRESCALE] = ~prescPin; // [R2]
      end
      ctsChg = (~modem.ctsN) != st_ff.modemStat[MSTS_CTS];
      dsrChg = (~modem.dsrN) != st_ff.modemStat[MSTS_DSR];
      // clear on read first, so a change in the same cycle still sets
      if (rdMsts) begin
         nxt.modemStat[MSTS_DELTA_CTS] = 1'b0;
         nxt.modemStat[MSTS_DELTA_DSR] = 1'b0;
      end
      if (ctsChg) begin
         nxt.modemStat[MSTS_DELTA_CTS] = 1'b1;
      end
      if (dsrChg) begin
         nxt.modemStat[MSTS_DELTA_DSR] = 1'b1;
      end
      nxt.modemStat[MSTS_CTS] = ~modem.ctsN; // [R6]
      nxt.modemStat[MSTS_DSR] = ~modem.dsrN; // [R9]
      // prescaler runs from the current ratio bit
      if (st_ff.modemCtrl[MCTL_PRESCALE]) begin
         nxt.presc = st_ff.presc + 2'h1; // [R1]
         nxt.tick = (st_ff.presc == PRESC_LAST);
      end else begin
         nxt.presc = PRESC_ZERO; // [R1]
         nxt.tick = 1'b1;
      end
      // low cts means the far end is ready to take data
      nxt.txAllow = ~st_ff.featReg[FEAT_AUTO_CTS] | ~modem.ctsN; // [R5] [R7]
      nxt.termReadyN = ~nxt.modemCtrl[MCTL_TERM_READY]; // [R10]
      pend = '0;
      pend[IRQ_RX_AVAIL] = src.rxAvail & st_ff.irqEn[IRQ_RX_AVAIL]; // [R12]
      pend[IRQ_TX_SPACE] = src.txSpace & st_ff.irqEn[IRQ_TX_SPACE];
      pend[IRQ_RX_ERROR] = src.rxError & st_ff.irqEn[IRQ_RX_ERROR];
      pend[IRQ_MODEM] = (st_ff.modemStat[MSTS_DELTA_CTS] | st_ff.modemStat[MSTS_DELTA_DSR])
         & st_ff.irqEn[IRQ_MODEM];
      nxt.irq = |pend; // [R11]
      // force pin overrides the enable bit; otherwise bit set means driven
      nxt.irqOeN = ~(forceIrq | st_ff.modemCtrl[MCTL_IRQ_OE]); // [R14] [R15]
   end

   // reset wins over the clock enable so the pins go quiet at once
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_ff <= CHAN_RST; // [R13] [R18]
      end else if (ce) begin
         st_ff <= nxt;
      end
   end

   // read mux, unmapped offsets read zero
   always_comb begin
      case (wr.addr)
         ADR_IRQ_ENABLE: rdData = st_ff.irqEn;
         ADR_IRQ_STATUS: rdData = {{(DATA_W-IRQ_SRC_W){1'b0}}, pend};
         ADR_FEATURE: rdData = st_ff.featReg;
         ADR_MODEM_CTRL: rdData = st_ff.modemCtrl;
         ADR_MODEM_STATUS: rdData = st_ff.modemStat;
         default: rdData = REG_RST;
      endcase
   end

   assign tick = st_ff.tick;
   assign txAllow = st_ff.txAllow;
   assign termReadyN = st_ff.termReadyN;
   assign irq = st_ff.irq;
   assign irqOeN = st_ff.irqOeN;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_strap_capture: // [R2]
      assert property (ce && capture |=> st_ff.modemCtrl[MCTL_PRESCALE] == !$past(prescPin))
      else $error("prescale bit is not the inverted strap");
   a_div_four_gap: // [R1]
      assert property (ce && tick && st_ff.modemCtrl[MCTL_PRESCALE] && !wr.stb && !capture
         |=> !tick)
      else $error("prescaler ticked twice in a row at divide by four");
   a_div_one_tick: // [R1]
      assert property (ce && !st_ff.modemCtrl[MCTL_PRESCALE] |=> tick)
      else $error("prescaler missed a tick at divide by one");
   a_ctrl_write: // [R3]
      assert property (ce && wr.stb && wr.addr == ADR_MODEM_CTRL && !capture
         |=> st_ff.modemCtrl == $past(wr.data))
      else $error("modem control write was not stored");
   a_ctrl_hold: // [R4]
      assert property (!wr.stb && !capture |=> $stable(st_ff.modemCtrl) && $stable(st_ff.irqEn))
      else $error("register changed without a write to this channel");
   a_cts_status: // [R6]
      assert property (ce |=> st_ff.modemStat[MSTS_CTS] == !$past(modem.ctsN))
      else $error("cts status bit does not follow the input");
   a_dsr_status: // [R9]
      assert property (ce |=> st_ff.modemStat[MSTS_DSR] == !$past(modem.dsrN))
      else $error("dsr status bit does not follow the input");
   a_auto_cts_off: // [R7]
      assert property (ce && !st_ff.featReg[FEAT_AUTO_CTS] |=> txAllow)
      else $error("cts gated transfer with auto cts off");
   a_irq_gate: // [R15]
      assert property (ce |=> irqOeN == !$past(forceIrq || st_ff.modemCtrl[MCTL_IRQ_OE]))
      else $error("irq output enable does not follow force pin and enable bit");
   a_irq_source: // [R12]
      assert property (ce && pend == '0 |=> !irq)
      else $error("interrupt raised without an enabled source");

   c_div_four: cover property (tick && st_ff.modemCtrl[MCTL_PRESCALE]);
   c_irq_driven: cover property (irq && !irqOeN);
endmodule

// ### src/uhp_pin_ctrl.sv
// What this block does
// (R1) Prescaler divides the input clock by one or four, per prescaler bit.
// (R2) At reset release the prescaler bit takes the inverted strap pin.
// (R3) Software may rewrite the prescaler bit after reset to change ratio.
// (R4) Host selects a channel with its low select; only selected channels transfer.
// (R5) Modem pulls clear-to-send low when it can accept transmit data.
// (R6) Clear-to-send level is readable in modem status bit four.
// (R7) Clear-to-send gates transfers only while auto clear-to-send is enabled.
// (R8) Eight-bit three-state data bus, bit zero least significant.
// (R9) Data-set-ready level is shown in each channel's modem status.
// (R10) Terminal-ready output is low while control bit zero is one.
// (R11) Interrupt output needs an enabled source; its output enable needs bit three or the force pin.
// (R12) Interrupt causes: receive error, receive data, transmit space, modem change.
// (R13) After reset all interrupt outputs are high impedance.
// (R14) Force pin high keeps interrupt outputs enabled regardless of bit three.
// (R15) Force pin low lets bit three enable the interrupt outputs.
// (R16) Falling read strobe puts the addressed register on the data bus.
// (R17) Rising write strobe stores the bus into the addressed selected register.
// (R18) Reset clears registers and outputs and disables serial transfer.
// (R19) Host keeps address and selects stable through a strobe, never both strobes.
// (R20) Data bus is released whenever no read is active for a selected channel.
module uhp_pin_ctrl
   import uhp_pkg::*;
#(
   parameter int NCH = NUM_CHAN
)
(
   // clock and control
   input wire logic clock,
   input wire logic rstn,
   input wire logic ce,
   // host bus pins
   input wire logic [NUM_CHAN-1:0] channelSelectN,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] hostDataIn,
   output logic [DATA_W-1:0] hostDataOut,
   output logic hostDataOeN,
   // configuration pins
   input wire logic prescaleSelectPin,
   input wire logic irqForceEnablePin,
   // modem pins per channel
   input wire logic [NUM_CHAN-1:0] ctsN,
   input wire logic [NUM_CHAN-1:0] dsrN,
   output logic [NUM_CHAN-1:0] terminalReadyN,
   // interrupt causes from the channel data paths
   input wire uhp_src_t [NUM_CHAN-1:0] chanSrc,
   // channel outputs
   output logic [NUM_CHAN-1:0] channelIrq,
   output logic [NUM_CHAN-1:0] channelIrqOeN,
   output logic [NUM_CHAN-1:0] prescaleTick,
   output logic [NUM_CHAN-1:0] txAllow,
   output logic serialEnable
);
   // the pin structs are sized by the package, so no other count fits
   if (NCH != NUM_CHAN) begin : g_bad_nch
      $error("uhp_pin_ctrl: NCH must equal the package channel count");
   end

   uhp_top_st_t st_ff;
   uhp_top_st_t nxt;
   uhp_top_st_t rstNxt;
   uhp_pins_t pinsNow;
   uhp_pins_t nxtFilt;
   uhp_wr_t [NUM_CHAN-1:0] chanWr;
   logic [NUM_CHAN-1:0] chanRdMsts;
   logic [DATA_W-1:0] chanRd [NUM_CHAN];
   logic [CH_IDX_W-1:0] sel;
   logic [DATA_W-1:0] readPick;
   logic rdFall;
   logic wrRise;
   logic anySel;

   // a bit of the filter moves only once the two later stages agree
   function automatic uhp_pins_t agreeFilter(uhp_pins_t a, uhp_pins_t b, uhp_pins_t held);
      logic [$bits(uhp_pins_t)-1:0] agree;
      agree = ~(a ^ b);
      return uhp_pins_t'((agree & b) | (~agree & held));
   endfunction

   // lowest numbered selected channel answers a read
   function automatic logic [CH_IDX_W-1:0] firstSel(logic [NUM_CHAN-1:0] csN);
      logic [CH_IDX_W-1:0] idx;
      idx = '0;
      for (int i = NUM_CHAN - 1; i >= 0; i--) begin
         if (!csN[i]) begin
            idx = CH_IDX_W'(i);
         end
      end
      return idx;
   endfunction

   // gather every asynchronous pin into one synchroniser word
   assign pinsNow = '{csN: channelSelectN, rdN: readStrobeN, wrN: writeStrobeN,
      addr: regAddr, data: hostDataIn, ctsN: ctsN, dsrN: dsrN,
      presc: prescaleSelectPin, irqForce: irqForceEnablePin};

   // next state: synchroniser, strobe edges, read capture and bus release
   always_comb begin
      nxt = st_ff;
      nxt.s1 = pinsNow;
      nxt.s2 = st_ff.s1;
      nxt.s3 = st_ff.s2;
      nxtFilt = agreeFilter(st_ff.s2, st_ff.s3, st_ff.filt);
      nxt.filt = nxtFilt;
      // address and selects are taken at the strobe edge, relying on them being stable
      rdFall = st_ff.filt.rdN & ~nxtFilt.rdN; // [R19]
      wrRise = ~st_ff.filt.wrN & nxtFilt.wrN; // [R19]
      anySel = ~&nxtFilt.csN;
      sel = firstSel(nxtFilt.csN);
      readPick = chanRd[sel];
      nxt.capture = 1'b0;
      nxt.serEn = 1'b1;
      for (int i = 0; i < NUM_CHAN; i++) begin
         chanWr[i].stb = wrRise & ~nxtFilt.csN[i]; // [R4] [R17]
         chanWr[i].addr = nxtFilt.addr;
         chanWr[i].data = nxtFilt.data; // [R8]
         chanRdMsts[i] = rdFall & ~nxtFilt.csN[i] & (sel == CH_IDX_W'(i))
            & (nxtFilt.addr == ADR_MODEM_STATUS);
      end
      // data is latched at the falling edge and held for the whole strobe
      if (rdFall && anySel) begin
         nxt.dout = readPick; // [R16]
         nxt.doeN = 1'b0;
      end else if (nxtFilt.rdN || !anySel) begin
         nxt.doeN = 1'b1; // [R20]
      end
      // the synchroniser keeps sampling in reset so the strap is settled at release
      rstNxt = TOP_RST;
      rstNxt.s1 = nxt.s1;
      rstNxt.s2 = nxt.s2;
      rstNxt.s3 = nxt.s3;
      rstNxt.filt = nxt.filt;
   end

   // reset takes priority over the clock enable
   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_ff <= rstNxt; // [R18]
      end else if (ce) begin
         st_ff <= nxt;
      end
   end

   // one register file per channel
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      uhp_chan u_chan (
         .clock(clock),
         .rstn(rstn),
         .ce(ce),
         .capture(st_ff.capture),
         .prescPin(st_ff.filt.presc),
         .forceIrq(st_ff.filt.irqForce),
         .wr(chanWr[i]),
         .rdMsts(chanRdMsts[i]),
         .rdData(chanRd[i]),
         .modem('{ctsN: st_ff.filt.ctsN[i], dsrN: st_ff.filt.dsrN[i]}),
         .src(chanSrc[i]),
         .tick(prescaleTick[i]),
         .txAllow(txAllow[i]),
         .termReadyN(terminalReadyN[i]),
         .irq(channelIrq[i]),
         .irqOeN(channelIrqOeN[i])
      );
   end

   // bus outputs straight from the state register
   assign hostDataOut = st_ff.dout; // [R8]
   assign hostDataOeN = st_ff.doeN;
   assign serialEnable = st_ff.serEn;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_read_drive: // [R16]
      assert property (ce && rdFall && anySel |=> !hostDataOeN && hostDataOut == $past(readPick))
      else $error("selected read did not drive the addressed register");
   a_bus_release: // [R20]
      assert property (ce && (nxtFilt.rdN || !anySel) |=> hostDataOeN)
      else $error("data bus driven without an active selected read");
   a_unsel_quiet: // [R4]
      assert property (ce && rdFall && !anySel |=> hostDataOeN)
      else $error("read answered with no channel selected");
   a_serial_off: // [R18]
      assert property ($rose(rstn) |-> !serialEnable && !(|txAllow) && (&terminalReadyN))
      else $error("outputs not cleared across reset");
   a_irq_hiz_reset: // [R13]
      assert property ($rose(rstn) |-> (&channelIrqOeN) && !(|channelIrq))
      else $error("interrupt outputs not high impedance after reset");
   a_force_enable: // [R14]
      assert property (ce && st_ff.filt.irqForce |=> channelIrqOeN == '0)
      else $error("force pin did not enable the interrupt outputs");
   a_term_ready: // [R10]
      assert property (ce && chanWr[0].stb && chanWr[0].addr == ADR_MODEM_CTRL
         |=> terminalReadyN[0] == !$past(chanWr[0].data[MCTL_TERM_READY]))
      else $error("terminal ready does not follow control bit zero");
   a_pin_to_drive: // [R16]
      assert property (ce && $fell(st_ff.s3.rdN) && st_ff.s2.rdN == st_ff.s3.rdN && anySel
         ##1 ce |=> !hostDataOeN)
      else $error("read strobe did not reach the bus in time");

   c_read_cycle: cover property (ce && rdFall && anySel ##[1:20] hostDataOeN);
   c_write_cycle: cover property (ce && wrRise && anySel);
endmodule

// ### src/uhp_pkg.sv
package uhp_pkg;
   // channel count and bus widths
   localparam int NUM_CHAN = 4;
   localparam int CH_IDX_W = 2;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;

   // register offsets inside each channel
   localparam logic [ADDR_W-1:0] ADR_IRQ_ENABLE = 3'h1;
   localparam logic [ADDR_W-1:0] ADR_IRQ_STATUS = 3'h2;
   localparam logic [ADDR_W-1:0] ADR_FEATURE = 3'h3;
   localparam logic [ADDR_W-1:0] ADR_MODEM_CTRL = 3'h4;
   localparam logic [ADDR_W-1:0] ADR_MODEM_STATUS = 3'h6;

   // interrupt source positions, same in enable and status registers
   localparam int IRQ_RX_AVAIL = 0;
   localparam int IRQ_TX_SPACE = 1;
   localparam int IRQ_RX_ERROR = 2;
   localparam int IRQ_MODEM = 3;
   localparam int IRQ_SRC_W = 4;

   // modem control, modem status and feature fields
   localparam int MCTL_TERM_READY = 0;
   localparam int MCTL_IRQ_OE = 3;
   localparam int MCTL_PRESCALE = 7;
   localparam int MSTS_DELTA_CTS = 0;
   localparam int MSTS_DELTA_DSR = 1;
   localparam int MSTS_CTS = 4;
   localparam int MSTS_DSR = 5;
   localparam int FEAT_AUTO_CTS = 7;

   // prescaler: counter wraps after four input clocks
   localparam int PRESC_W = 2;
   localparam logic [PRESC_W-1:0] PRESC_LAST = 2'h3;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 2'h0;
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;

   // interrupt causes coming from the channel data path
   typedef struct packed {
      logic rxError;
      logic rxAvail;
      logic txSpace;
   } uhp_src_t;

   // one register write towards a channel
   typedef struct packed {
      logic stb;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } uhp_wr_t;

   // filtered modem inputs of one channel
   typedef struct packed {
      logic ctsN;
      logic dsrN;
   } uhp_modem_t;

   // every pin that crosses into the clock domain
   typedef struct packed {
      logic [NUM_CHAN-1:0] csN;
      logic rdN;
      logic wrN;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [NUM_CHAN-1:0] ctsN;
      logic [NUM_CHAN-1:0] dsrN;
      logic presc;
      logic irqForce;
   } uhp_pins_t;

   typedef struct packed {
      logic [DATA_W-1:0] irqEn;
      logic [DATA_W-1:0] featReg;
      logic [DATA_W-1:0] modemCtrl;
      logic [DATA_W-1:0] modemStat;
      logic [PRESC_W-1:0] presc;
      logic tick;
      logic txAllow;
      logic termReadyN;
      logic irq;
      logic irqOeN;
   } uhp_chan_st_t;

   typedef struct packed {
      uhp_pins_t s1;
      uhp_pins_t s2;
      uhp_pins_t s3;
      uhp_pins_t filt;
      logic capture;
      logic [DATA_W-1:0] dout;
      logic doeN;
      logic serEn;
   } uhp_top_st_t;

   localparam uhp_chan_st_t CHAN_RST = '{irqEn: REG_RST, featReg: REG_RST,
      modemCtrl: REG_RST, modemStat: REG_RST, presc: PRESC_ZERO, tick: 1'b0,
      txAllow: 1'b0, termReadyN: 1'b1, irq: 1'b0, irqOeN: 1'b1};

   localparam uhp_top_st_t TOP_RST = '{s1: '1, s2: '1, s3: '1, filt: '1,
      capture: 1'b1, dout: REG_RST, doeN: 1'b1, serEn: 1'b0};
endpackage

// ### tb/tb_top.sv
module tb_top
   import uhp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rstn, ce, readStrobeN, writeStrobeN, hostDataOeN;
   logic prescaleSelectPin, irqForceEnablePin, serialEnable;
   logic [NUM_CHAN-1:0] channelSelectN, ctsN, dsrN, terminalReadyN;
   logic [NUM_CHAN-1:0] channelIrq, channelIrqOeN, prescaleTick, txAllow;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] hostDataIn, hostDataOut;
   uhp_src_t [NUM_CHAN-1:0] chanSrc;
   int errTotal = 0;
   int checkCount = 0;
   int n;

   uhp_pin_ctrl #(.NCH(4)) u_uhp_pin_ctrl (.clock(clock), .rstn(rstn), .ce(ce),
      .channelSelectN(channelSelectN), .readStrobeN(readStrobeN),
      .writeStrobeN(writeStrobeN), .regAddr(regAddr), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN),
      .prescaleSelectPin(prescaleSelectPin), .irqForceEnablePin(irqForceEnablePin),
      .ctsN(ctsN), .dsrN(dsrN), .terminalReadyN(terminalReadyN), .chanSrc(chanSrc),
      .channelIrq(channelIrq), .channelIrqOeN(channelIrqOeN),
      .prescaleTick(prescaleTick), .txAllow(txAllow), .serialEnable(serialEnable));

   uhp_host_model u_host (.clock(clock), .csN(channelSelectN), .rdN(readStrobeN),
      .wrN(writeStrobeN), .addr(regAddr), .busIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic summarize();
      $display("errors %0d checks %0d", errTotal, checkCount);
      if (errTotal == 0 && checkCount > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // masked register read; a read with no select must leave the bus released
   task automatic rdchk(input logic [3:0] cs, input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      u_host.rd(cs, a, d, ok);
      if (cs == 4'hf) begin
         check({7'h0, ok}, 8'h00);
      end else if (!ok) begin
         errTotal++;
         $display("CHECK FAILED %0t read timeout", $time);
         summarize();
      end else begin
         check(d & m, exp);
      end
      check({7'h0, hostDataOeN}, 8'h01);
   endtask

   task automatic waitn(input int c);
      repeat (c) @(negedge clock);
   endtask

   // bound on the whole run so a hang still reaches the verdict
   initial begin
      repeat (20000) @(posedge clock);
      errTotal++;
      summarize();
   end

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      prescaleSelectPin = 1'b0;
      irqForceEnablePin = 1'b0;
      ctsN = 4'hf;
      dsrN = 4'hf;
      chanSrc = '0;
      waitn(5);
      check({4'h0, terminalReadyN}, 8'h0f);
      check({4'h0, channelIrqOeN}, 8'h0f);
      check({7'h0, serialEnable}, 8'h00);
      check({7'h0, hostDataOeN}, 8'h01);
      @(posedge clock);
      rstn <= 1'b1;
      waitn(2);
      check({7'h0, serialEnable}, 8'h01);
      check({4'h0, channelIrqOeN}, 8'h0f);
      // low strap gives divide by four
      rdchk(4'he, ADR_MODEM_CTRL, 8'hff, 8'h80);
      n = 0;
      repeat (8) begin
         @(negedge clock);
         n += prescaleTick[0];
      end
      check(n[7:0], 8'h02);
      u_host.wr(4'he, ADR_MODEM_CTRL, 8'h00);
      waitn(2);
      repeat (3) begin
         @(negedge clock);
         check({7'h0, prescaleTick[0]}, 8'h01);
      end
      n = 0;
      repeat (8) begin
         @(negedge clock);
         n += prescaleTick[1];
      end
      check(n[7:0], 8'h02);
      // terminal ready only on the selected channels
      u_host.wr(4'h9, ADR_MODEM_CTRL, 8'h01);
      check({4'h0, terminalReadyN}, 8'h09);
      u_host.wr(4'hb, ADR_MODEM_CTRL, 8'h00);
      check({4'h0, terminalReadyN}, 8'h0d);
      // enable low freezes the pin filter, so a whole write goes unseen
      ce <= 1'b0;
      u_host.wr(4'he, ADR_MODEM_CTRL, 8'h01);
      check({4'h0, terminalReadyN}, 8'h0d);
      ce <= 1'b1;
      rdchk(4'hd, ADR_MODEM_CTRL, 8'hff, 8'h01);
      // modem levels in the status register
      ctsN <= 4'hb;
      dsrN <= 4'h7;
      waitn(6);
      rdchk(4'hb, ADR_MODEM_STATUS, 8'h30, 8'h10);
      rdchk(4'h7, ADR_MODEM_STATUS, 8'h30, 8'h20);
      // clear-to-send gates transfers only with auto mode on
      check({7'h0, txAllow[3]}, 8'h01);
      u_host.wr(4'h7, ADR_FEATURE, 8'h80);
      check({7'h0, txAllow[3]}, 8'h00);
      ctsN[3] <= 1'b0;
      waitn(6);
      check({7'h0, txAllow[3]}, 8'h01);
      rdchk(4'he, 3'h7, 8'hff, 8'h00);
      rdchk(4'hf, ADR_MODEM_CTRL, 8'hff, 8'h00);
      // a source without its enable stays quiet
      chanSrc[0] <= uhp_src_t'(3'h2);
      waitn(3);
      check({7'h0, channelIrq[0]}, 8'h00);
      u_host.wr(4'he, ADR_IRQ_ENABLE, 8'h07);
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         chanSrc[0] <= uhp_src_t'(3'h1 << i);
         waitn(3);
         check({7'h0, channelIrq[0]}, 8'h01);
      end
      @(posedge clock);
      chanSrc[0] <= uhp_src_t'(3'h0);
      waitn(3);
      check({7'h0, channelIrq[0]}, 8'h00);
      // modem change as a cause, cleared by reading the status
      u_host.wr(4'he, ADR_IRQ_ENABLE, 8'h08);
      ctsN[0] <= 1'b0;
      // four filter edges, one for the status flag, one for the interrupt
      waitn(7);
      check({7'h0, channelIrq[0]}, 8'h01);
      rdchk(4'he, ADR_IRQ_STATUS, 8'hff, 8'h08);
      rdchk(4'he, ADR_MODEM_STATUS, 8'h01, 8'h01);
      waitn(3);
      check({7'h0, channelIrq[0]}, 8'h00);
      // output enable by control bit, then by the force pin
      check({7'h0, channelIrqOeN[0]}, 8'h01);
      u_host.wr(4'he, ADR_MODEM_CTRL, 8'h08);
      check({7'h0, channelIrqOeN[0]}, 8'h00);
      u_host.wr(4'he, ADR_MODEM_CTRL, 8'h00);
      check({7'h0, channelIrqOeN[0]}, 8'h01);
      irqForceEnablePin <= 1'b1;
      waitn(6);
      check({4'h0, channelIrqOeN}, 8'h00);
      // second reset with the strap high selects divide by one
      @(posedge clock);
      rstn <= 1'b0;
      prescaleSelectPin <= 1'b1;
      waitn(5);
      check({4'h0, channelIrqOeN}, 8'h0f);
      check({4'h0, terminalReadyN}, 8'h0f);
      @(posedge clock);
      rstn <= 1'b1;
      waitn(3);
      check({4'h0, prescaleTick}, 8'h0f);
      rdchk(4'he, ADR_MODEM_CTRL, 8'hff, 8'h00);
      summarize();
   end
endmodule

// ### tb/uhp_host_model.sv
module uhp_host_model
   import uhp_pkg::*;
(
   // clock
   input wire logic clock,
   // host bus pins
   output logic [NUM_CHAN-1:0] csN,
   output logic rdN,
   output logic wrN,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] busIn,
   input wire logic [DATA_W-1:0] hostDataOut,
   input wire logic hostDataOeN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] wdat;
   logic drv;

   // bus level: nothing pulls it, so an undriven bus shows the inverse of the last write
   assign busIn = !hostDataOeN ? hostDataOut : (drv ? wdat : ~wdat);

   initial begin
      csN = 4'hf;
      rdN = 1'b1;
      wrN = 1'b1;
      addr = 3'h0;
      wdat = 8'h00;
      drv = 1'b0;
   end

   // strobe held four cycles so the pin filter sees it; pins held well past its end
   task automatic wr(input logic [3:0] cs, input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      csN <= cs;
      addr <= a;
      wdat <= d;
      drv <= 1'b1;
      wrN <= 1'b0;
      repeat (4) @(posedge clock);
      wrN <= 1'b1;
      repeat (6) @(posedge clock);
      csN <= 4'hf;
      drv <= 1'b0;
   endtask

   // only one strobe at a time; data taken at the edge that sees the bus driven
   task automatic rd(input logic [3:0] cs, input logic [2:0] a, output logic [7:0] d,
                     output logic ok);
      int n;
      @(posedge clock);
      csN <= cs;
      addr <= a;
      rdN <= 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 10 && !ok; n++) begin
         @(posedge clock);
         if (hostDataOeN === 1'b0) begin
            ok = 1'b1;
            d = hostDataOut;
         end
      end
      rdN <= 1'b1;
      repeat (5) @(posedge clock);
      csN <= 4'hf;
   endtask
endmodule
